// ==== logic/video_output_format_power_control.sv ====
// Operation
// - Two-bit drive level for fast outputs except vsync, address LSB, field.
// - Format field: 00 RGB 4:4:4, 01 4:2:2, 10 DDR 4:4:4; default 00.
// - In 4:2:2 only sixteen pixel pins are active, not twenty-four; the code drives each group by its own enable, so 0, 8, 16 or 24.
// - DDR 4:4:4 sends RGB data changing on both output clock edges.
// - Code 11 is 12-bit 4:2:2, allowed only with the digital source.
// - Primary group red/green floats when its enable is 0 in 4:2:2 and DDR modes; default 1.
// - Secondary group blue carries DDR YCrCb, floats when enable 0 in 4:2:2 and DDR modes.
// - Global float bit floats every output except green sync.
// - Own bit floats the green sync output when set.
// - Own bit floats the S/PDIF output pins when set.
// - Own bit floats the I2S output pins when set.
// - Polarity bit: 0 sleep pin active low, 1 active high; default 1.
// - Active sleep pin: function code picks power-down and which pins float.
// - Inactive sleep pin keeps the part powered whatever the function code.
// - Software sleep floats syncs, data clock and data; green sync stays.
// - Register port and sync logic keep working during power-down.
// - Auto sleep bit powers down while no sync input is seen.
// - A bit supplies the content protection bus address LSB; default 0.
// - Audio master clock select: 0 internal, 1 external input.
// - Clock mismatch drops or repeats audio samples, never stalls.
`include "vofpc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module video_output_format_power_control #(
  parameter logic [6:0] SLAVE_ADDR = 7'h4c
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pix_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sleep_input_pin,
  input wire logic sync_present,
  input wire logic tmds_source,
  input wire logic [23:0] video_in,
  input wire vofpc_pkg::sync_s sync_in,
  input wire logic green_sync_in,
  input wire vofpc_pkg::audio_s audio_in,
  output logic [23:0] video_rise,
  output logic [23:0] video_fall,
  output vofpc_pkg::sync_s sync_out,
  output logic green_sync_output,
  output vofpc_pkg::audio_s audio_out,
  output logic red_green_oe,
  output logic blue_oe,
  output logic sync_oe,
  output logic pixel_data_clock_oe,
  output logic green_sync_oe,
  output logic spdif_oe,
  output logic i2s_oe,
  output logic [1:0] drive_level,
  output logic core_sleep,
  output logic address_lsb_pin,
  output logic external_audio_clock_select
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [3:0] meta_q;
  logic [3:0] syn_q;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_s;
  logic sda_s;
  logic sleep_s;
  logic sync_s_w;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  logic byte_done;
  vofpc_pkg::ser_state_e st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic nack_q;
  logic wr_stb;
  logic [7:0] rd_data;
  logic [1:0] drive_q;
  logic [1:0] fmt_q;
  logic pri_q;
  logic sec_q;
  logic gfloat_q;
  logic sogf_q;
  logic spdf_q;
  logic i2sf_q;
  logic pol_q;
  logic [1:0] pfunc_q;
  logic swslp_q;
  logic auto_q;
  logic alsb_q;
  logic mclk_q;
  logic pin_act;
  logic float_main;
  logic float_sog;
  logic all_lanes;
  logic [1:0] eff_fmt;
  logic [1:0] snap_q;
  logic req_q;
  logic ack_m_q;
  logic ack_s_q;
  logic prst_m_q;
  logic prst_q;
  logic req_m_q;
  logic req_s_q;
  logic req_p_q;
  logic ack_q;
  vofpc_pkg::fmt_e pfmt_q;
  logic phase_q;
  logic [7:0] in_r;
  logic [7:0] in_g;
  logic [7:0] in_b;
  logic [7:0] chroma;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // Bus pins start at their idle high level, so no false edge
      meta_q <= 4'hc;
      syn_q <= 4'hc;
    end else begin
      meta_q <= {scl_in, sda_in, sleep_input_pin, sync_present};
      syn_q <= meta_q;
    end
  end

  assign scl_s = syn_q[3];
  assign sda_s = syn_q[2];
  assign sleep_s = syn_q[1];
  assign sync_s_w = syn_q[0];

  // Previous bus levels for edge and framing detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign rise_c = scl_s & ~scl_p_q;
  assign fall_c = ~scl_s & scl_p_q;
  assign byte_done = fall_c & (cnt_q == `BYTE_BITS);

  //////////////////////////////////////////////////////////////////////////
  // Serial register port; never gated by any sleep state

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= vofpc_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (start_c) begin
      st_q <= vofpc_pkg::ST_ADDR;
      cnt_q <= 4'h0;
    end else if (stop_c) begin
      st_q <= vofpc_pkg::ST_IDLE;
    end else begin
      case (st_q)
        vofpc_pkg::ST_ADDR, vofpc_pkg::ST_PTR, vofpc_pkg::ST_WR: begin
          if (rise_c) begin
            sh_q <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end
          if (byte_done) begin
            case (st_q)
              vofpc_pkg::ST_ADDR: begin
                rw_q <= sh_q[0];
                // Foreign addresses leave the bus untouched
                st_q <= (sh_q[7:1] == SLAVE_ADDR) ?
                        vofpc_pkg::ST_ADDR_ACK : vofpc_pkg::ST_IDLE;
              end
              vofpc_pkg::ST_PTR: begin
                ptr_q <= sh_q;
                st_q <= vofpc_pkg::ST_PTR_ACK;
              end
              default: st_q <= vofpc_pkg::ST_WR_ACK;
            endcase
          end
        end
        vofpc_pkg::ST_ADDR_ACK: begin
          if (fall_c) begin
            cnt_q <= 4'h0;
            tx_q <= rd_data;
            st_q <= rw_q ? vofpc_pkg::ST_RD : vofpc_pkg::ST_PTR;
          end
        end
        vofpc_pkg::ST_PTR_ACK: begin
          if (fall_c) begin
            cnt_q <= 4'h0;
            st_q <= vofpc_pkg::ST_WR;
          end
        end
        vofpc_pkg::ST_WR_ACK: begin
          if (fall_c) begin
            cnt_q <= 4'h0;
            ptr_q <= ptr_q + 8'h01;
            st_q <= vofpc_pkg::ST_WR;
          end
        end
        vofpc_pkg::ST_RD: begin
          if (rise_c) begin
            cnt_q <= cnt_q + 4'h1;
          end
          if (byte_done) begin
            ptr_q <= ptr_q + 8'h01;
            st_q <= vofpc_pkg::ST_RD_ACK;
          end else if (fall_c) begin
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        vofpc_pkg::ST_RD_ACK: begin
          if (rise_c) begin
            nack_q <= sda_s;
          end
          if (fall_c) begin
            cnt_q <= 4'h0;
            tx_q <= rd_data;
            st_q <= nack_q ? vofpc_pkg::ST_IDLE : vofpc_pkg::ST_RD;
          end
        end
        default: st_q <= vofpc_pkg::ST_IDLE;
      endcase
    end
  end

  // Open drain: only ever pulls low, one cycle behind the state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= ~start_c & ~stop_c &
                ((st_q == vofpc_pkg::ST_ADDR_ACK) |
                 (st_q == vofpc_pkg::ST_PTR_ACK) |
                 (st_q == vofpc_pkg::ST_WR_ACK) |
                 ((st_q == vofpc_pkg::ST_RD) & ~tx_q[7]));
    end
  end

  assign wr_stb = (st_q == vofpc_pkg::ST_WR) & byte_done & ~start_c &
                  ~stop_c;

  // Readback; unmapped offsets and spare bits read zero
  always_comb begin
    case (ptr_q)
      `OFS_FORMAT: rd_data = {2'h0, drive_q, fmt_q, pri_q, sec_q};
      `OFS_FLOAT: rd_data = {gfloat_q, sogf_q, spdf_q, i2sf_q, pol_q,
                             pfunc_q, swslp_q};
      `OFS_MISC: rd_data = {auto_q, alsb_q, mclk_q, 5'h00};
      default: rd_data = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Control registers

  // Format register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive_q <= `RST_DRIVE;
      fmt_q <= `RST_FMT;
      pri_q <= `RST_PRI;
      sec_q <= `RST_SEC;
    end else if (wr_stb && ptr_q == `OFS_FORMAT) begin
      drive_q <= sh_q[`POS_DRIVE+1:`POS_DRIVE];
      fmt_q <= sh_q[`POS_FMT+1:`POS_FMT];
      pri_q <= sh_q[`POS_PRI];
      sec_q <= sh_q[`POS_SEC];
    end
  end

  // Float and sleep register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gfloat_q <= `RST_FLOATS;
      sogf_q <= `RST_FLOATS;
      spdf_q <= `RST_FLOATS;
      i2sf_q <= `RST_FLOATS;
      pol_q <= `RST_POL;
      pfunc_q <= `RST_PFUNC;
      swslp_q <= `RST_SWSLP;
    end else if (wr_stb && ptr_q == `OFS_FLOAT) begin
      gfloat_q <= sh_q[`POS_GFLOAT];
      sogf_q <= sh_q[`POS_SOGF];
      spdf_q <= sh_q[`POS_SPDF];
      i2sf_q <= sh_q[`POS_I2SF];
      pol_q <= sh_q[`POS_POL];
      pfunc_q <= sh_q[`POS_PFUNC+1:`POS_PFUNC];
      swslp_q <= sh_q[`POS_SWSLP];
    end
  end

  // Misc register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      auto_q <= `RST_AUTO;
      alsb_q <= `RST_ALSB;
      mclk_q <= `RST_MCLK;
    end else if (wr_stb && ptr_q == `OFS_MISC) begin
      auto_q <= sh_q[`POS_AUTO];
      alsb_q <= sh_q[`POS_ALSB];
      mclk_q <= sh_q[`POS_MCLK];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Power and pad enables, kept on sys_clk so floats work without pix_clk

  assign pin_act = pol_q ? sleep_s : ~sleep_s;
  // Every pin function code floats all but green sync; odd codes add it
  assign float_main = gfloat_q | pin_act;
  assign float_sog = sogf_q | (pin_act & pfunc_q[0]);
  // RGB 4:4:4 and 12-bit formats use all lanes, ignoring group enables
  assign all_lanes = (eff_fmt == vofpc_pkg::FMT_444) |
                     (eff_fmt == vofpc_pkg::FMT_422_12);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      red_green_oe <= 1'b0;
      blue_oe <= 1'b0;
      sync_oe <= 1'b0;
      pixel_data_clock_oe <= 1'b0;
      green_sync_oe <= 1'b0;
      spdif_oe <= 1'b0;
      i2s_oe <= 1'b0;
    end else begin
      red_green_oe <= ~float_main & ~swslp_q & (all_lanes | pri_q);
      blue_oe <= ~float_main & ~swslp_q & (all_lanes | sec_q);
      sync_oe <= ~float_main & ~swslp_q;
      pixel_data_clock_oe <= ~float_main & ~swslp_q;
      green_sync_oe <= ~float_sog;
      spdif_oe <= ~float_main & ~spdf_q;
      i2s_oe <= ~float_main & ~i2sf_q;
    end
  end

  // Core power state; pin codes with the high bit clear power down
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_sleep <= 1'b0;
      drive_level <= `RST_DRIVE;
      address_lsb_pin <= `RST_ALSB;
      external_audio_clock_select <= `RST_MCLK;
    end else begin
      core_sleep <= swslp_q | (pin_act & ~pfunc_q[1]) |
                    (auto_q & ~sync_s_w);
      drive_level <= drive_q;
      address_lsb_pin <= alsb_q;
      // Audio path never waits on the master clock choice
      external_audio_clock_select <= mclk_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Format handover to the pixel domain by request/acknowledge toggle

  // 12-bit mode falls back to 4:4:4 on the analog path
  assign eff_fmt = (fmt_q == vofpc_pkg::FMT_422_12 && !tmds_source) ?
                   vofpc_pkg::FMT_444 : fmt_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      snap_q <= `RST_FMT;
      req_q <= 1'b0;
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
    end else begin
      ack_m_q <= ack_q;
      ack_s_q <= ack_m_q;
      // Snapshot only moves when the last one was taken
      if (req_q == ack_s_q && eff_fmt != snap_q) begin
        snap_q <= eff_fmt;
        req_q <= ~req_q;
      end
    end
  end

  // Reset and request synchronisers on pix_clk
  always_ff @(posedge pix_clk) begin
    prst_m_q <= rst;
    prst_q <= prst_m_q;
  end

  always_ff @(posedge pix_clk) begin
    if (prst_q) begin
      req_m_q <= 1'b0;
      req_s_q <= 1'b0;
      req_p_q <= 1'b0;
      ack_q <= 1'b0;
      pfmt_q <= vofpc_pkg::FMT_444;
    end else begin
      req_m_q <= req_q;
      req_s_q <= req_m_q;
      req_p_q <= req_s_q;
      ack_q <= req_s_q;
      if (req_s_q != req_p_q) begin
        pfmt_q <= vofpc_pkg::fmt_e'(snap_q);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pixel formatter; inputs are 4:4:4 with red=Cr, green=Y, blue=Cb

  assign in_r = video_in[23:16];
  assign in_g = video_in[15:8];
  assign in_b = video_in[7:0];
  assign chroma = phase_q ? in_r : in_b;

  // Chroma phase restarts at each active line
  always_ff @(posedge pix_clk) begin
    if (prst_q) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= sync_in.de & ~phase_q;
    end
  end

  // Lane layout per format; fall word goes out on the falling edge
  always_ff @(posedge pix_clk) begin
    if (prst_q) begin
      video_rise <= 24'h000000;
      video_fall <= 24'h000000;
    end else begin
      case (pfmt_q)
        vofpc_pkg::FMT_422: begin
          video_rise <= {chroma, in_g, in_g};
          video_fall <= {chroma, in_g, chroma};
        end
        vofpc_pkg::FMT_DDR444: begin
          video_rise <= {in_r, in_g, in_g};
          video_fall <= {in_b, in_g, chroma};
        end
        vofpc_pkg::FMT_422_12: begin
          video_rise <= {in_r, in_g, in_b};
          video_fall <= {in_r, in_g, in_b};
        end
        default: begin
          video_rise <= video_in;
          video_fall <= video_in;
        end
      endcase
    end
  end

  // Sync and audio retimed to match the data latency
  always_ff @(posedge pix_clk) begin
    if (prst_q) begin
      sync_out <= '0;
      green_sync_output <= 1'b0;
      audio_out <= '0;
    end else begin
      sync_out <= sync_in;
      green_sync_output <= green_sync_in;
      audio_out <= audio_in;
    end
  end

endmodule : video_output_format_power_control
`default_nettype wire

// ==== logic/vofpc_params.svh ====
`ifndef VOFPC_PARAMS_SVH
`define VOFPC_PARAMS_SVH
// Register offsets on the serial port
`define OFS_FORMAT 8'h25
`define OFS_FLOAT 8'h26
`define OFS_MISC 8'h27
// Field positions in the format register
`define POS_DRIVE 4
`define POS_FMT 2
`define POS_PRI 1
`define POS_SEC 0
// Field positions in the float register
`define POS_GFLOAT 7
`define POS_SOGF 6
`define POS_SPDF 5
`define POS_I2SF 4
`define POS_POL 3
`define POS_PFUNC 1
`define POS_SWSLP 0
// Field positions in the misc register
`define POS_AUTO 7
`define POS_ALSB 6
`define POS_MCLK 5
// Reset values
`define RST_DRIVE 2'h3
`define RST_FMT 2'h0
`define RST_PRI 1'h1
`define RST_SEC 1'h0
`define RST_FLOATS 1'h0
`define RST_POL 1'h1
`define RST_PFUNC 2'h0
`define RST_SWSLP 1'h0
`define RST_AUTO 1'h1
`define RST_ALSB 1'h0
`define RST_MCLK 1'h0
// Serial port bits per byte
`define BYTE_BITS 4'h8
`endif

// ==== logic/vofpc_pkg.sv ====
package vofpc_pkg;
  typedef enum logic [1:0] {
    FMT_444 = 2'h0,
    FMT_422 = 2'h1,
    FMT_DDR444 = 2'h2,
    FMT_422_12 = 2'h3
  } fmt_e;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_PTR = 9'h008,
    ST_PTR_ACK = 9'h010,
    ST_WR = 9'h020,
    ST_WR_ACK = 9'h040,
    ST_RD = 9'h080,
    ST_RD_ACK = 9'h100
  } ser_state_e;
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic de;
    logic field;
  } sync_s;
  typedef struct packed {
    logic spdif;
    logic sck;
    logic ws;
    logic [3:0] sd;
  } audio_s;
endpackage : vofpc_pkg

// ==== bench/vofpc_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module vofpc_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pix_clk,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire vofpc_pkg::sync_s sync_in,
  input wire vofpc_pkg::audio_s audio_in,
  input wire logic green_sync_in,
  input wire vofpc_pkg::sync_s sync_out,
  input wire vofpc_pkg::audio_s audio_out,
  input wire logic green_sync_output,
  input wire logic red_green_oe,
  input wire logic blue_oe,
  input wire logic sync_oe,
  input wire logic pixel_data_clock_oe,
  input wire logic spdif_oe,
  input wire logic i2s_oe,
  input wire logic [1:0] drive_level,
  input wire logic core_sleep,
  input wire logic address_lsb_pin,
  input wire logic external_audio_clock_select
);
  logic [2:0] pix_age_q;
  //////////////////////////////////////////////////////////////////////////
  // Pixel cycles since reset; the pixel side sees reset late
  always_ff @(posedge pix_clk) begin
    if (rst) begin
      pix_age_q <= 3'h0;
    end else if (pix_age_q != 3'h7) begin
      pix_age_q <= pix_age_q + 3'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Enable relations; software and auto sleep keep audio, so audio is tied to float only
  a_clk_with_sync: assert property (@(posedge sys_clk) disable iff (rst)
    sync_oe == pixel_data_clock_oe) else $error("clock and sync oe differ");
  a_data_needs_sync: assert property (@(posedge sys_clk) disable iff (rst)
    !sync_oe |-> !red_green_oe && !blue_oe) else $error("data driven in float");
  a_audio_float_glob: assert property (@(posedge sys_clk) disable iff (rst)
    (!sync_oe && !core_sleep) [*4] |-> !spdif_oe && !i2s_oe)
    else $error("audio driven in float");
  // Serial port: open drain, moves only while the clock is low
  a_ack_quiet_reset: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rst) |-> !sda_oe [*3]) else $error("data line pulled after reset");
  a_sda_low_only: assert property (@(posedge sys_clk) disable iff (rst)
    sda_out == 1'b0) else $error("data line driven high");
  a_sda_moves_low: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(sda_oe) |-> !scl_in) else $error("data line moved, clock high");
  a_regs_move_low: assert property (@(posedge sys_clk) disable iff (rst)
    $changed({drive_level, address_lsb_pin, external_audio_clock_select})
    |-> !scl_in) else $error("register copy moved, clock high");
  a_pix_pass_delay: assert property (@(posedge pix_clk) disable iff (rst)
    pix_age_q == 3'h7 |-> sync_out == $past(sync_in)
    && audio_out == $past(audio_in)
    && green_sync_output == $past(green_sync_in))
    else $error("side-band not one cycle late");
endmodule : vofpc_checker
bind video_output_format_power_control vofpc_checker u_checker (
  .sys_clk(sys_clk), .rst(rst), .pix_clk(pix_clk), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .sync_in(sync_in),
  .audio_in(audio_in), .sync_out(sync_out), .audio_out(audio_out),
  .green_sync_in(green_sync_in), .green_sync_output(green_sync_output),
  .red_green_oe(red_green_oe), .blue_oe(blue_oe), .sync_oe(sync_oe),
  .pixel_data_clock_oe(pixel_data_clock_oe), .spdif_oe(spdif_oe),
  .i2s_oe(i2s_oe), .drive_level(drive_level), .core_sleep(core_sleep),
  .address_lsb_pin(address_lsb_pin),
  .external_audio_clock_select(external_audio_clock_select)
);
`default_nettype wire

// ==== bench/pixel_sink.sv ====
`timescale 1ns/1ns
`default_nettype none
module pixel_sink (
  input wire logic pix_clk,
  input wire logic [23:0] video_rise,
  input wire logic [23:0] video_fall,
  input wire logic red_green_oe,
  input wire logic blue_oe,
  output logic [23:0] rise_seen,
  output logic [23:0] fall_seen
);
  // Floated lanes have no pull: they show the inverse of the last word
  always @(posedge pix_clk) begin
    rise_seen <= {red_green_oe ? video_rise[23:8] : ~rise_seen[23:8],
      blue_oe ? video_rise[7:0] : ~rise_seen[7:0]};
  end
  // Falling half of a double rate word is taken on the falling edge
  always @(negedge pix_clk) begin
    fall_seen <= {red_green_oe ? video_fall[23:8] : ~fall_seen[23:8],
      blue_oe ? video_fall[7:0] : ~fall_seen[7:0]};
  end
endmodule : pixel_sink
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [6:0] SLAVE = 7'h4c;
  logic sys_clk = 1'b0;
  logic pix_clk = 1'b0;
  logic rst = 1'b1;
  logic scl = 1'b1;
  logic pull = 1'b0;
  logic pin = 1'b0;
  logic sync_seen = 1'b1;
  logic tmds = 1'b0;
  logic [11:0] pat = 12'h000;
  logic sda_oe, sda_out, rg_oe, b_oe, s_oe, c_oe, g_oe, sp_oe, i2_oe;
  logic slp, lsb, mclk_ext, sog;
  logic [1:0] drive;
  logic [23:0] vr, vf, rise_seen, fall_seen;
  logic [7:0] rd, cv, ex, oe_now;
  logic ack;
  vofpc_pkg::sync_s sync_o;
  vofpc_pkg::audio_s audio_o;
  wire sda_line;
  int mismatches = 0;
  int total_checks = 0;
  logic [9:0] cases [14] = '{10'h021, 10'h221, 10'h121, 10'h0a1, 10'h061,
    10'h025, 10'h023, 10'h02b, 10'h033, 10'h03b, 10'h039, 10'h001,
    10'h003, 10'h020};
  // Open-drain data line, high unless someone pulls it
  assign sda_line = !(sda_oe || pull);
  assign oe_now = {rg_oe, b_oe, s_oe, c_oe, g_oe, sp_oe, i2_oe, slp};
  initial forever #20 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #32 pix_clk = ~pix_clk;
  end
  // Side-band moves on the pixel clock, so audio stays locked to video
  always @(negedge pix_clk) pat <= pat + 12'h001;
  video_output_format_power_control #(.SLAVE_ADDR(SLAVE)) dut (
    .sys_clk(sys_clk), .rst(rst), .pix_clk(pix_clk), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .sleep_input_pin(pin), .sync_present(sync_seen), .tmds_source(tmds),
    .video_in(24'h123456), .sync_in(vofpc_pkg::sync_s'(pat[3:0])),
    .green_sync_in(pat[11]), .audio_in(vofpc_pkg::audio_s'(pat[10:4])),
    .video_rise(vr), .video_fall(vf), .sync_out(sync_o),
    .green_sync_output(sog), .audio_out(audio_o), .red_green_oe(rg_oe),
    .blue_oe(b_oe), .sync_oe(s_oe), .pixel_data_clock_oe(c_oe),
    .green_sync_oe(g_oe), .spdif_oe(sp_oe), .i2s_oe(i2_oe),
    .drive_level(drive), .core_sleep(slp), .address_lsb_pin(lsb),
    .external_audio_clock_select(mclk_ext)
  );
  pixel_sink sink (
    .pix_clk(pix_clk), .video_rise(vr), .video_fall(vf),
    .red_green_oe(rg_oe), .blue_oe(b_oe), .rise_seen(rise_seen),
    .fall_seen(fall_seen)
  );
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  // Bit cells of 12 cycles: data moves a cycle after the clock falls
  task automatic send_bit(input logic b);
    pull = !b;
    tick(5);
    scl = 1'b1;
    tick(6);
    scl = 1'b0;
    tick(1);
  endtask : send_bit
  task automatic get_bit(output logic b);
    pull = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(3);
    b = sda_line;
    tick(3);
    scl = 1'b0;
    tick(1);
  endtask : get_bit
  task automatic start_c;
    pull = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(6);
    pull = 1'b1;
    tick(6);
    scl = 1'b0;
    tick(1);
  endtask : start_c
  task automatic stop_c;
    pull = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(6);
    pull = 1'b0;
    tick(6);
  endtask : stop_c
  task automatic put_byte(input logic [7:0] v, output logic a);
    logic b;
    for (int i = 7; i >= 0; i--) send_bit(v[i]);
    get_bit(b);
    a = !b;
  endtask : put_byte
  task automatic get_byte(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) get_bit(v[i]);
    send_bit(1'b1);
  endtask : get_byte
  // Register write, then time for enables to follow
  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] v);
    logic a0, a1, a2;
    start_c;
    put_byte({SLAVE, 1'b0}, a0);
    put_byte(ofs, a1);
    put_byte(v, a2);
    stop_c;
    check({a0, a1, a2}, 24'h7);
    tick(8);
  endtask : reg_wr
  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    logic a0, a1, a2;
    start_c;
    put_byte({SLAVE, 1'b0}, a0);
    put_byte(ofs, a1);
    start_c;
    put_byte({SLAVE, 1'b1}, a2);
    get_byte(rd);
    stop_c;
    check({a0, a1, a2, rd}, {3'h7, exp});
  endtask : rd_chk
  // Expected enables and sleep from the float register, pin and sync
  function automatic logic [7:0] want(input logic [7:0] r, input logic p,
      input logic s);
    logic act, fm;
    act = r[3] ? p : !p;
    fm = r[7] | act;
    return {{4{!fm & !r[0]}}, !(r[6] | act & r[1]), !fm & !r[5],
      !fm & !r[4], r[0] | act & !r[2] | !s};
  endfunction : want
  task automatic fmt_case(input logic [7:0] v, input logic t,
      input logic [1:0] e);
    tmds = t;
    reg_wr(8'h25, v);
    check({rg_oe, b_oe}, {22'h0, e});
    rd_chk(8'h25, v);
  endtask : fmt_case
  task automatic done_test(input string n);
    $display("test %s done, %0d bad so far", n, mismatches);
  endtask : done_test
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  //////////////////////////////////////////////////////////////////////////
  // Hang guard: a stuck run counts as a mismatch
  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    print_verdict;
  end
  initial begin
    tick(12);
    rst = 1'b0;
    tick(4);
    check(drive, 24'h3);
    check({rg_oe, b_oe, lsb, mclk_ext}, 24'hc);
    rd_chk(8'h25, 8'h32);
    rd_chk(8'h26, 8'h08);
    rd_chk(8'h27, 8'h80);
    rd_chk(8'h30, 8'h00);
    check(rise_seen, 24'h123456);
    check(fall_seen, 24'h123456);
    done_test("reset");
    for (int k = 0; k < 4; k++) begin
      reg_wr(8'h25, {2'h0, 2'(k), 4'h2});
      check(drive, 24'(k));
    end
    done_test("drive");
    fmt_case(8'h36, 1'b0, 2'h2);
    check({rise_seen[15:8], fall_seen[15:8]}, 24'h3434);
    fmt_case(8'h35, 1'b0, 2'h1);
    fmt_case(8'h38, 1'b0, 2'h0);
    fmt_case(8'h3b, 1'b0, 2'h3);
    tick(20);
    check(rise_seen[23:8], 24'h1234);
    check(fall_seen[23:16], 24'h56);
    fmt_case(8'h3c, 1'b1, 2'h3);
    check(rise_seen, 24'h123456);
    fmt_case(8'h32, 1'b0, 2'h3);
    done_test("format");
    for (int i = 0; i < 14; i++) begin
      cv = cases[i][9:2];
      pin = cases[i][1];
      sync_seen = cases[i][0];
      reg_wr(8'h26, cv);
      ex = want(cv, pin, sync_seen);
      check(oe_now[7:1], ex[7:1]);
      check(oe_now[0], ex[0]);
      rd_chk(8'h26, cv);
    end
    pin = 1'b0;
    sync_seen = 1'b1;
    reg_wr(8'h26, 8'h08);
    done_test("float");
    sync_seen = 1'b0;
    reg_wr(8'h27, 8'h60);
    check({lsb, mclk_ext, slp}, 24'h6);
    rd_chk(8'h27, 8'h60);
    reg_wr(8'h27, 8'h80);
    check({lsb, mclk_ext, slp}, 24'h1);
    sync_seen = 1'b1;
    done_test("misc");
    start_c;
    put_byte({SLAVE ^ 7'h01, 1'b0}, ack);
    stop_c;
    check(ack, 24'h0);
    rd_chk(8'h25, 8'h32);
    done_test("serial");
    print_verdict;
  end
endmodule : tb
`default_nettype wire
